// [verilog/serial_output_clock_generator.sv]
// Our own choice: register access over AXI4-Lite.
`include "serial_clock_consts.svh"

module serial_output_clock_generator #(
  parameter int AddrWidth = 18
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    syncInPulse,
  output logic                         serialClk,
  output logic                         bitStrobe,
  output logic [3:0]                   serialReset,
  input  wire logic [AddrWidth-1:0]    s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire serial_clock_pkg::word_t s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output serial_clock_pkg::resp_t      s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AddrWidth-1:0]    s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output serial_clock_pkg::word_t      s_axi_rdata,
  output serial_clock_pkg::resp_t      s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import serial_clock_pkg::*;

  if (AddrWidth < 18 || AddrWidth > 32) begin : g_bad_addr
    $error("AddrWidth must be 18 to 32");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [`CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
  logic [3:0]             syncSel_reg, syncSel_next;
  logic                   awHave_reg, awHave_next, wHave_reg, wHave_next;
  logic [AddrWidth-1:0]   awAddr_reg, awAddr_next;
  word_t                  wData_reg, wData_next;
  logic [3:0]             wStrb_reg, wStrb_next;
  logic                   awready_reg, awready_next, wready_reg, wready_next;
  logic                   bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic                   rvalid_reg, rvalid_next;
  resp_t                  bresp_reg, bresp_next, rresp_reg, rresp_next;
  word_t                  rdata_reg, rdata_next;
  logic                   waitSync_reg, serialClk_reg;
  logic                   running;

  function automatic logic isAddr(logic [AddrWidth-1:0] a, logic [31:0] b);
    return {a[AddrWidth-1:2], 2'b00} == b[AddrWidth-1:0];
  endfunction

  always_comb begin
    ctrl_next    = ctrl_reg;
    syncSel_next = syncSel_reg;
    awHave_next  = awHave_reg;
    wHave_next   = wHave_reg;
    awAddr_next  = awAddr_reg;
    wData_next   = wData_reg;
    wStrb_next   = wStrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_awvalid && awready_reg) begin
      awHave_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      wHave_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (awHave_reg && wHave_reg && !bvalid_reg) begin
      awHave_next = 1'b0;
      wHave_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `RESP_OKAY;
      if (isAddr(awAddr_reg, `SCLK_CTRL_ADDR)) begin
        if (wStrb_reg[0]) begin
          ctrl_next = wData_reg[`CTRL_WIDTH-1:0];
        end
      end else if (isAddr(awAddr_reg, `SYNC_SEL_ADDR)) begin
        if (wStrb_reg[3]) syncSel_next[0] = wData_reg[`SYNC_CH0_BIT];
        if (wStrb_reg[2]) syncSel_next[1] = wData_reg[`SYNC_CH1_BIT];
        if (wStrb_reg[1]) syncSel_next[2] = wData_reg[`SYNC_CH2_BIT];
        if (wStrb_reg[0]) syncSel_next[3] = wData_reg[`SYNC_CH3_BIT];
      end else if (!isAddr(awAddr_reg, `SCLK_STAT_ADDR)) begin
        bresp_next = `RESP_SLVERR;
      end
    end
    awready_next = !awHave_next;
    wready_next  = !wHave_next;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = '0;
      rresp_next   = `RESP_OKAY;
      if (isAddr(s_axi_araddr, `SCLK_CTRL_ADDR)) begin
        rdata_next[`CTRL_WIDTH-1:0] = ctrl_reg;
      end else if (isAddr(s_axi_araddr, `SYNC_SEL_ADDR)) begin
        rdata_next[`SYNC_CH0_BIT] = syncSel_reg[0];
        rdata_next[`SYNC_CH1_BIT] = syncSel_reg[1];
        rdata_next[`SYNC_CH2_BIT] = syncSel_reg[2];
        rdata_next[`SYNC_CH3_BIT] = syncSel_reg[3];
      end else if (isAddr(s_axi_araddr, `SCLK_STAT_ADDR)) begin
        rdata_next[`STAT_HELD_BIT] = ctrl_reg[`CTRL_HOLD_BIT] && waitSync_reg;
        rdata_next[`STAT_RUN_BIT]  = running;
        rdata_next[`STAT_CLK_BIT]  = serialClk_reg;
      end else begin
        rresp_next = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= `CTRL_RESET;
      syncSel_reg <= `SYNC_SEL_RESET;
      awHave_reg  <= 1'b0;
      wHave_reg   <= 1'b0;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb_reg   <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `RESP_OKAY;
    end else begin
      ctrl_reg    <= ctrl_next;
      syncSel_reg <= syncSel_next;
      awHave_reg  <= awHave_next;
      wHave_reg   <= wHave_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ---------------------------------------------------------------
  // Bit clock divider
  // ---------------------------------------------------------------
  rate_t      rate;
  ratio_t     ratio;
  logic [3:0] cnt_reg, cnt_next, half;
  logic       holdBit, divRstEn, pol, divClear;
  logic       waitSync_next, serialClk_next, bitStrobe_reg, bitStrobe_next;
  logic [3:0] serialReset_reg, serialReset_next;

  always_comb begin
    rate     = ctrl_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
    holdBit  = ctrl_reg[`CTRL_HOLD_BIT];
    divRstEn = ctrl_reg[`CTRL_DIVRST_BIT];
    pol      = ctrl_reg[`CTRL_POL_BIT];
    case (rate)
      `RATE_DIV1:  ratio = 5'd1;
      `RATE_DIV2:  ratio = 5'd2;
      `RATE_DIV4:  ratio = 5'd4;
      `RATE_DIV8:  ratio = 5'd8;
      `RATE_DIV16: ratio = 5'd16;
      default:     ratio = 5'd0;
    endcase
    half          = ratio[4:1];
    running       = (ratio != 5'd0) && !(holdBit && waitSync_reg);
    divClear      = syncInPulse && divRstEn && (|syncSel_reg);
    waitSync_next = waitSync_reg && !syncInPulse;
    serialReset_next = syncSel_reg & {4{syncInPulse}};
    if (!running || divClear || ({1'b0, cnt_reg} >= ratio - 5'd1)) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
    if (!running) begin
      serialClk_next = !pol;
    end else if (ratio == 5'd1) begin
      serialClk_next = !serialClk_reg;
    end else begin
      serialClk_next = (cnt_reg >= half) ? pol : !pol;
    end
    bitStrobe_next = running && (cnt_reg == 4'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg         <= 4'h0;
      waitSync_reg    <= 1'b1;
      serialClk_reg   <= 1'b1;
      bitStrobe_reg   <= 1'b0;
      serialReset_reg <= 4'h0;
    end else begin
      cnt_reg         <= cnt_next;
      waitSync_reg    <= waitSync_next;
      serialClk_reg   <= serialClk_next;
      bitStrobe_reg   <= bitStrobe_next;
      serialReset_reg <= serialReset_next;
    end
  end

  assign serialClk   = serialClk_reg;
  assign bitStrobe   = bitStrobe_reg;
  assign serialReset = serialReset_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic steady;
  assign steady = !syncInPulse && !(awHave_reg && wHave_reg);

  chk_hold_stops_clk: assert property (
    (holdBit && waitSync_reg) |=> (serialClk_reg == !$past(pol)) && !bitStrobe_reg)
    else $error("bit clock moved while held for sync");
  chk_div_clear: assert property (
    divClear |=> (cnt_reg == 4'h0))
    else $error("divider not cleared by sync");
  chk_rise_centre: assert property (
    (running && pol && ratio > 5'd1 && cnt_reg == half && steady)
      |=> serialClk_reg && $past(!serialClk_reg))
    else $error("rising edge not at bit centre");
  chk_fall_centre: assert property (
    (running && !pol && ratio > 5'd1 && cnt_reg == half && steady)
      |=> !serialClk_reg && $past(serialClk_reg))
    else $error("falling edge not at bit centre");
  chk_off_full: assert property (
    (rate == `RATE_OFF) |=> !bitStrobe_reg ##0 (serialClk_reg == !$past(pol)))
    else $error("stopped clock still toggling");
  chk_full_rate: assert property (
    (running && rate == `RATE_DIV1 && steady) |=> bitStrobe_reg && (serialClk_reg != $past(serialClk_reg)))
    else $error("full rate clock missed a cycle");

  chk_half_period: assert property (
    (running && steady && rate == `RATE_DIV2 && cnt_reg == 4'h0) ##1 (running && steady)[*2]
      |-> !bitStrobe_reg && $past(bitStrobe_reg) ##1 bitStrobe_reg)
    else $error("half rate period wrong");
  chk_quarter_period: assert property (
    (running && steady && rate == `RATE_DIV4 && cnt_reg == 4'h0) ##1 (running && steady)[*4]
      |-> !bitStrobe_reg && !$past(bitStrobe_reg, 1) && !$past(bitStrobe_reg, 2) && $past(bitStrobe_reg, 3)
      ##1 bitStrobe_reg)
    else $error("quarter rate period wrong");
  chk_eighth_period: assert property (
    (running && steady && rate == `RATE_DIV8 && cnt_reg == 4'h0) ##1 (running && steady)[*8]
      |-> !bitStrobe_reg && !$past(bitStrobe_reg, 1) && !$past(bitStrobe_reg, 2) && !$past(bitStrobe_reg, 3)
      && !$past(bitStrobe_reg, 4) && !$past(bitStrobe_reg, 5) && !$past(bitStrobe_reg, 6)
      && $past(bitStrobe_reg, 7) ##1 bitStrobe_reg)
    else $error("eighth rate period wrong");

  chk_chan_reset: assert property (
    syncInPulse |=> (serialReset_reg == $past(syncSel_reg)))
    else $error("channel sync reset mismatch");
  chk_undef_rate: assert property (
    (rate[2:1] == 2'b11) |=> !bitStrobe_reg && (cnt_reg == 4'h0))
    else $error("undefined rate code ran the clock");

  chk_hold_release: assert property (
    (waitSync_reg && syncInPulse) |=> !waitSync_reg)
    else $error("sync pulse did not release the hold");
  chk_clear_restart: assert property (
    (divClear && running) ##1 running |-> ##1 bitStrobe_reg)
    else $error("bit did not restart after divider clear");
  chk_reset_quiet: assert property (
    !syncInPulse |=> (serialReset_reg == 4'h0))
    else $error("channel reset without sync pulse");

  cov_sixteenth: cover property (bitStrobe_reg && rate == `RATE_DIV16 ##16 bitStrobe_reg);
  cov_hold_release: cover property (holdBit && waitSync_reg ##1 !waitSync_reg ##1 bitStrobe_reg);
  cov_full_rate: cover property (running && rate == `RATE_DIV1 ##1 bitStrobe_reg);
  cov_div_clear: cover property (divClear && cnt_reg != 4'h0);
  cov_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule : serial_output_clock_generator

// [shared/serial_clock_consts.svh]
`ifndef SERIAL_CLOCK_CONSTS_SVH
`define SERIAL_CLOCK_CONSTS_SVH

// Register indexes; byte address is four times the index
`define SCLK_CTRL_IDX      16'hf803
`define SYNC_SEL_IDX       16'hf802
`define SCLK_STAT_IDX      16'hf810
`define SCLK_CTRL_ADDR     (32'h0000_f803 * 4)
`define SYNC_SEL_ADDR      (32'h0000_f802 * 4)
`define SCLK_STAT_ADDR     (32'h0000_f810 * 4)

// Control fields
`define CTRL_HOLD_BIT      5
`define CTRL_DIVRST_BIT    4
`define CTRL_POL_BIT       3
`define CTRL_RATE_MSB      2
`define CTRL_RATE_LSB      0
`define CTRL_WIDTH         6
`define CTRL_RESET         6'h00

// Per-channel sync-reset bit positions, channel 0 first
`define SYNC_CH0_BIT       24
`define SYNC_CH1_BIT       16
`define SYNC_CH2_BIT       8
`define SYNC_CH3_BIT       0
`define SYNC_SEL_RESET     4'h0

// Rate codes
`define RATE_OFF           3'h0
`define RATE_DIV1          3'h1
`define RATE_DIV2          3'h2
`define RATE_DIV4          3'h3
`define RATE_DIV8          3'h4
`define RATE_DIV16         3'h5

// Status fields
`define STAT_HELD_BIT      0
`define STAT_RUN_BIT       1
`define STAT_CLK_BIT       2

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// [shared/serial_clock_pkg.sv]
package serial_clock_pkg;
  typedef logic [2:0]  rate_t;
  typedef logic [1:0]  resp_t;
  typedef logic [31:0] word_t;
  typedef logic [4:0]  ratio_t;
endpackage : serial_clock_pkg

// [dv/serial_link_receiver.sv]
module serial_link_receiver (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic serialClk,
  input  wire logic bitStrobe,
  output int        bitCount,
  output int        bitPeriod,
  output logic      startLevel,
  output logic      midLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap;
  // --------
  // Bit length and clock level at bit start and bit centre
  // --------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCount   <= 0;
      bitPeriod  <= 0;
      gap        <= 0;
      startLevel <= 1'b0;
      midLevel   <= 1'b0;
    end else if (bitStrobe) begin
      bitCount   <= bitCount + 1;
      bitPeriod  <= gap + 1;
      gap        <= 0;
      startLevel <= serialClk;
    end else begin
      gap <= gap + 1;
      if (gap + 1 == bitPeriod / 2) begin
        midLevel <= serialClk;
      end
    end
  end
endmodule // serial_link_receiver

// [dv/serial_output_clock_generator_bench.sv]
`include "serial_clock_consts.svh"

module serial_output_clock_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_clock_pkg::*;
  localparam logic [17:0] CtrlAddr = 18'(`SCLK_CTRL_ADDR);
  localparam logic [17:0] SelAddr  = 18'(`SYNC_SEL_ADDR);
  localparam logic [17:0] StatAddr = 18'(`SCLK_STAT_ADDR);
  logic        clk, rst_n, syncInPulse, serialClk, bitStrobe;
  logic [3:0]  serialReset, s_axi_wstrb;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, startLevel, midLevel;
  word_t       s_axi_wdata, s_axi_rdata;
  resp_t       s_axi_bresp, s_axi_rresp;
  int          bitCount, bitPeriod, error_cnt, comparisons, cyc, n, n0;
  logic [31:0] sel;

  serial_output_clock_generator serial_output_clock_generator_i (.clk, .rst_n, .syncInPulse, .serialClk,
    .bitStrobe, .serialReset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  serial_link_receiver serial_link_receiver_i (.clk, .rst_n, .serialClk, .bitStrobe, .bitCount,
    .bitPeriod, .startLevel, .midLevel);

  // --------
  // Shared tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [17:0] a, input word_t d, input logic [3:0] s, input resp_t er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axr(input string nm, input logic [17:0] a, input word_t e, input resp_t er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic pulse_sync;
    @(posedge clk);
    syncInPulse <= 1'b1;
    @(posedge clk);
    syncInPulse <= 1'b0;
  endtask

  task automatic sync_check(input logic [3:0] expRst, input logic expStrobe);
    int hits;
    hits = 0;
    do @(posedge clk); while (!bitStrobe);
    pulse_sync();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      if (i == 1) chk("divider cleared", 32'(expStrobe), 32'(bitStrobe));
      if (serialReset !== 4'h0) begin
        hits++;
        chk("serialReset", 32'(expRst), 32'(serialReset));
      end
    end
    chk("reset pulses", 32'(expRst != 4'h0), 32'(hits));
  endtask

  task close_out;
    $display("Compares %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // --------
  // Clock, watchdog and tests
  // --------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 4000) begin
        error_cnt++;
        close_out();
      end
    end
  end

  initial begin
    {rst_n, syncInPulse, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk("idle level", 32'h1, 32'(serialClk));
    axr("ctrl reset", CtrlAddr, 32'h0, `RESP_OKAY);
    axr("unmapped", 18'h00100, 32'h0, `RESP_SLVERR);
    axw(18'h00100, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    axw(CtrlAddr, 32'h22, 4'hf, `RESP_OKAY);
    axw(CtrlAddr, 32'h3f, 4'he, `RESP_OKAY);
    axr("ctrl", CtrlAddr, 32'h22, `RESP_OKAY);
    axw(StatAddr, 32'h0, 4'hf, `RESP_OKAY);
    repeat (30) @(posedge clk);
    chk("held bits", 32'h0, 32'(bitCount));
    axr("status", StatAddr, 32'h5, `RESP_OKAY);
    pulse_sync();
    repeat (30) @(posedge clk);
    chk("bit period", 32'h2, 32'(bitPeriod));
    $display("Test hold and registers done");
    for (int code = 0; code < 8; code++) begin
      axw(CtrlAddr, 32'(code) | (32'(code % 2) << 3), 4'hf, `RESP_OKAY);
      repeat (60) @(posedge clk);
      n0 = bitCount;
      repeat (40) @(posedge clk);
      n = (code >= 1 && code <= 5) ? (1 << (code - 1)) : 0;
      if (n == 0) begin
        chk("stopped bits", 32'(n0), 32'(bitCount));
        chk("idle level", 32'(1 - code % 2), 32'(serialClk));
      end else begin
        chk("bit period", 32'(n), 32'(bitPeriod));
        if (n > 1) begin
          chk("start level", 32'(1 - code % 2), 32'(startLevel));
          chk("centre level", 32'(code % 2), 32'(midLevel));
        end
      end
    end
    $display("Test rates and polarity done");
    for (int i = 0; i < 3; i++) begin
      sel = (i == 2) ? 32'h0 : 32'h0100_0100;
      axw(SelAddr, sel, 4'hf, `RESP_OKAY);
      axr("sync select", SelAddr, sel, `RESP_OKAY);
      axw(CtrlAddr, 32'h05 | (32'(i != 0) << 4), 4'hf, `RESP_OKAY);
      repeat (40) @(posedge clk);
      sync_check((sel != 0) ? 4'h5 : 4'h0, (i != 0) && (sel != 0));
    end
    $display("Test sync done");
    close_out();
  end
endmodule // serial_output_clock_generator_bench
